// [rtl/sms_defines.vh]
// Register map, field positions and reset values of the status block.
// Assumes byte addresses on a 32-bit AXI4-Lite bus, one register a word.
`ifndef SMS_DEFINES_VH
`define SMS_DEFINES_VH
`define SMS_IDX_OPT      8'h13
`define SMS_IDX_STS1     8'h14
`define SMS_IDX_STS2     8'h15
`define SMS_ADDR_W       12
`define SMS_OPT_RESET    8'h44
`define SMS_STS1_BASE    8'h02
`define SMS_STS2_RESET   8'h00
`define SMS_OPT_MASK     8'h77
`define SMS_B_BAT        0
`define SMS_B_PAR        1
`define SMS_B_U2         2
`define SMS_B_U1         3
`define SMS_B_FDC        4
`define SMS_B_WDT        7
`define SMS_B_MOUSE      0
`define SMS_B_KBD        1
`define SMS_B_IR         2
`define SMS_B_CLICK      4
`define SMS_O_EN3        0
`define SMS_O_SEL3       1
`define SMS_O_POL3       2
`define SMS_O_EN4        4
`define SMS_O_SEL4       5
`define SMS_O_POL4       6
`define SMS_RESP_OKAY    2'b00
`define SMS_RESP_SLVERR  2'b10
`endif

// [rtl/sms_status.v]
// Status collection and serial direction options, AXI4-Lite slave.
// Assumes all event inputs are synchronous to clk_sys; power-on and
// reset events arrive as one-cycle pulses from the power logic.
//
// Chosen here: the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "sms_defines.vh"
module sms_status (
	clk_sys,
	reset_n,
	s_axi_awaddr,
	s_axi_awvalid,
	s_axi_awready,
	s_axi_wdata,
	s_axi_wstrb,
	s_axi_wvalid,
	s_axi_wready,
	s_axi_bresp,
	s_axi_bvalid,
	s_axi_bready,
	s_axi_araddr,
	s_axi_arvalid,
	s_axi_arready,
	s_axi_rdata,
	s_axi_rresp,
	s_axi_rvalid,
	s_axi_rready,
	standby_por,
	main_por,
	bus_reset,
	soft_reset,
	battery_swapped,
	battery_below_low,
	battery_below_high,
	parallel_active,
	printer_acknowledge_input,
	second_uart_irq,
	first_uart_irq,
	floppy_irq,
	watchdog_event,
	mouse_irq,
	keyboard_irq,
	infrared_receive_input,
	mouse_click_event,
	third_tx_active,
	fourth_tx_active,
	third_rts_in,
	third_dtr_in,
	fourth_rts_in,
	fourth_dtr_in,
	third_request_to_send_output,
	third_terminal_ready_output,
	fourth_request_to_send_output,
	fourth_terminal_ready_output
);
	input  wire        clk_sys;
	input  wire        reset_n;
	input  wire [11:0] s_axi_awaddr;
	input  wire        s_axi_awvalid;
	output reg         s_axi_awready;
	input  wire [31:0] s_axi_wdata;
	input  wire [3:0]  s_axi_wstrb;
	input  wire        s_axi_wvalid;
	output reg         s_axi_wready;
	output reg  [1:0]  s_axi_bresp;
	output reg         s_axi_bvalid;
	input  wire        s_axi_bready;
	input  wire [11:0] s_axi_araddr;
	input  wire        s_axi_arvalid;
	output reg         s_axi_arready;
	output reg  [31:0] s_axi_rdata;
	output reg  [1:0]  s_axi_rresp;
	output reg         s_axi_rvalid;
	input  wire        s_axi_rready;
	input  wire        standby_por;
	input  wire        main_por;
	input  wire        bus_reset;
	input  wire        soft_reset;
	input  wire        battery_swapped;
	input  wire        battery_below_low;
	input  wire        battery_below_high;
	input  wire        parallel_active;
	input  wire        printer_acknowledge_input;
	input  wire        second_uart_irq;
	input  wire        first_uart_irq;
	input  wire        floppy_irq;
	input  wire        watchdog_event;
	input  wire        mouse_irq;
	input  wire        keyboard_irq;
	input  wire        infrared_receive_input;
	input  wire        mouse_click_event;
	input  wire        third_tx_active;
	input  wire        fourth_tx_active;
	input  wire        third_rts_in;
	input  wire        third_dtr_in;
	input  wire        fourth_rts_in;
	input  wire        fourth_dtr_in;
	output reg         third_request_to_send_output;
	output reg         third_terminal_ready_output;
	output reg         fourth_request_to_send_output;
	output reg         fourth_terminal_ready_output;

	// Bus notes: each ready is a one-cycle pulse re-armed only while its
	// channel is idle, which cuts peak throughput to one transfer in three cycles but keeps one write
	// and one read in flight with no queue. Only byte lane 0 is stored;
	// upper data bits read zero. Unmapped words answer with an error.
	//
	// Event notes: the level flags are shown live so that clearing at the
	// source takes effect on the next read; only battery-low, infrared,
	// mouse-click and the parallel-flag forcing hold state here. Power and reset events are single
	// cycle pulses; when one meets a software clear of the same flag in
	// one cycle, the hardware set always wins.
	// The parallel flag is forced high by every reset event until the
	// port is activated afresh.

	// Word index decode, shared by read and write paths
	// (a decode miss gives code zero, answered with an error)
	function [1:0] reg_sel;
		input [11:0] addr;
		begin
			if (addr == {2'b00, `SMS_IDX_OPT, 2'b00})
				reg_sel = 2'd1;
			else if (addr == {2'b00, `SMS_IDX_STS1, 2'b00})
				reg_sel = 2'd2;
			else if (addr == {2'b00, `SMS_IDX_STS2, 2'b00})
				reg_sel = 2'd3;
			else
				reg_sel = 2'd0;
		end
	endfunction

	// State held by the block
	reg  [7:0]  opt_q;
	reg         bat_q;
	reg         ir_q;
	reg         click_q;
	reg         ir_prev_q;
	reg         aw_got_q;
	reg         w_got_q;
	reg  [11:0] awaddr_q;
	reg  [31:0] wdata_q;
	reg         wstrb0_q;
	reg         par_force_q;
	reg         par_act_prev_q;
	reg         ir_armed_q;

	// Handshakes and the write commit
	wire        aw_hs = s_axi_awvalid & s_axi_awready;
	wire        w_hs  = s_axi_wvalid & s_axi_wready;
	wire        ar_hs = s_axi_arvalid & s_axi_arready;
	// Write commits once both halves are held and no response is pending
	wire        wr_go = aw_got_q & w_got_q & ~s_axi_bvalid;
	wire [1:0]  wr_sel = reg_sel(awaddr_q);
	wire [1:0]  rd_sel = reg_sel(s_axi_araddr);
	wire        wr_one = wr_go & wstrb0_q;
	wire [7:0]  wbyte = wdata_q[7:0];
	// Per-register write strobes; lane 0 off leaves every register alone
	wire        wr_opt  = wr_one & (wr_sel == 2'd1);
	wire        wr_sts1 = wr_one & (wr_sel == 2'd2);
	wire        wr_sts2 = wr_one & (wr_sel == 2'd3);
	// Any of the four reset events forces the parallel flag high
	wire        any_reset_evt = standby_por | main_por | bus_reset |
		soft_reset;

	// Live status images; reserved bits are tied to zero
	wire        par_flag = (parallel_active & ~par_force_q) ?
		printer_acknowledge_input : 1'b1;
	wire [7:0]  sts1 = {watchdog_event, 2'b00, floppy_irq, first_uart_irq,
		second_uart_irq, par_flag, bat_q};
	wire [7:0]  sts2 = {3'b000, click_q, 1'b0, ir_q, keyboard_irq,
		mouse_irq};
	// A taken read of status two clears the infrared flag
	wire        rd_sts2 = ar_hs & (rd_sel == 2'd3);

	// Write channel: each half is taken on its own, in either order.
	// The commit waits while a response is still pending, so a held
	// answer is never overwritten by the next write.
	always @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			aw_got_q      <= 1'b0;
			w_got_q       <= 1'b0;
			awaddr_q      <= 12'h000;
			wdata_q       <= 32'h00000000;
			wstrb0_q      <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `SMS_RESP_OKAY;
		end else begin
			s_axi_awready <= ~aw_got_q & ~aw_hs & ~s_axi_awready;
			s_axi_wready  <= ~w_got_q & ~w_hs & ~s_axi_wready;
			if (aw_hs) begin
				aw_got_q <= 1'b1;
				awaddr_q <= s_axi_awaddr;
			end
			if (w_hs) begin
				w_got_q  <= 1'b1;
				wdata_q  <= s_axi_wdata;
				wstrb0_q <= s_axi_wstrb[0];
			end
			if (wr_go) begin
				aw_got_q     <= 1'b0;
				w_got_q      <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (wr_sel == 2'd0) ? `SMS_RESP_SLVERR
					: `SMS_RESP_OKAY;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Read channel: one read under way; address taken only while idle.
	// Data are captured at the address edge, so a read-side clear of the
	// infrared flag and the data shown to software refer to one instant.
	always @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h00000000;
			s_axi_rresp   <= `SMS_RESP_OKAY;
		end else begin
			s_axi_arready <= ~s_axi_rvalid & ~ar_hs & ~s_axi_arready;
			if (ar_hs) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp  <= `SMS_RESP_OKAY;
				case (rd_sel)
				2'd1: s_axi_rdata <= {24'h000000, opt_q};
				2'd2: s_axi_rdata <= {24'h000000, sts1};
				2'd3: s_axi_rdata <= {24'h000000, sts2};
				default: begin
					s_axi_rdata <= 32'h00000000;
					s_axi_rresp <= `SMS_RESP_SLVERR;
				end
				endcase
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// Option register; reserved bits never store. Standby power-on puts
	// both ports back to plain modem outputs with auto control off.
	always @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			opt_q <= `SMS_OPT_RESET;
		end else if (standby_por) begin
			opt_q <= `SMS_OPT_RESET;
		end else if (wr_opt) begin
			opt_q <= wbyte & `SMS_OPT_MASK;
		end
	end

	// Battery-low: power-on events set it; set beats a same-cycle clear.
	// The supply comparators are only looked at on the power-on pulses,
	// so a dip between those events is not seen here by design.
	always @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			bat_q <= 1'b0;
		end else if (standby_por) begin
			bat_q <= battery_swapped | battery_below_low;
		end else if (main_por && battery_below_high) begin
			bat_q <= 1'b1;
		end else if (wr_sts1 && wbyte[`SMS_B_BAT]) begin
			bat_q <= 1'b0;
		end
	end

	// Forcing of the parallel flag: every reset event sets it, and only a
	// fresh activation of the port afterwards lets the acknowledge input
	// through again. A reset event in the activation cycle wins, so the
	// flag never shows a stale acknowledge level straight after a reset.
	always @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			par_force_q    <= 1'b1;
			par_act_prev_q <= 1'b0;
		end else begin
			par_act_prev_q <= parallel_active;
			if (any_reset_evt)
				par_force_q <= 1'b1;
			else if (parallel_active && !par_act_prev_q)
				par_force_q <= 1'b0;
		end
	end

	// Status two latched flags; hardware set wins over clear. The edge
	// detector is armed one cycle after reset so that a receive line
	// idling high does not fake a transition at start-up.
	always @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			ir_prev_q  <= 1'b0;
			ir_armed_q <= 1'b0;
			ir_q       <= 1'b0;
			click_q    <= 1'b0;
		end else begin
			ir_prev_q  <= infrared_receive_input;
			ir_armed_q <= 1'b1;
			if (standby_por) begin
				ir_q    <= 1'b0;
				click_q <= 1'b0;
			end else begin
				if (ir_armed_q &&
					infrared_receive_input != ir_prev_q)
					ir_q <= 1'b1;
				else if (rd_sts2)
					ir_q <= 1'b0;
				if (mouse_click_event)
					click_q <= 1'b1;
				else if (wr_sts2 && wbyte[`SMS_B_CLICK])
					click_q <= 1'b0;
			end
		end
	end

	// Drive of one direction pin: under auto control the selected pin
	// follows the transmitter at the chosen level, else it passes the
	// UART's own modem output so the port keeps working as a plain UART
	function dir_drive;
		input en;
		input picked;
		input pol;
		input tx;
		input modem;
		begin
			dir_drive = (en & picked) ? (tx ~^ pol) : modem;
		end
	endfunction

	// Direction pins: pass modem lines through except the pin picked under auto control.
	// Registered so the pins are glitch-free; they lag the transmitter
	// and the option register by one clock.
	always @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			third_request_to_send_output  <= 1'b1;
			third_terminal_ready_output   <= 1'b1;
			fourth_request_to_send_output <= 1'b1;
			fourth_terminal_ready_output  <= 1'b1;
		end else begin
			third_request_to_send_output <= dir_drive(opt_q[`SMS_O_EN3],
				opt_q[`SMS_O_SEL3], opt_q[`SMS_O_POL3],
				third_tx_active, third_rts_in);
			third_terminal_ready_output <= dir_drive(opt_q[`SMS_O_EN3],
				~opt_q[`SMS_O_SEL3], opt_q[`SMS_O_POL3],
				third_tx_active, third_dtr_in);
			fourth_request_to_send_output <= dir_drive(opt_q[`SMS_O_EN4],
				opt_q[`SMS_O_SEL4], opt_q[`SMS_O_POL4],
				fourth_tx_active, fourth_rts_in);
			fourth_terminal_ready_output <= dir_drive(opt_q[`SMS_O_EN4],
				~opt_q[`SMS_O_SEL4], opt_q[`SMS_O_POL4],
				fourth_tx_active, fourth_dtr_in);
		end
	end

endmodule // sms_status

// [verif/smi_status_and_rs485_dir_options_bench.sv]
// Self-checking bench: register bus tasks and event stimulus.
// Assumes rtl/ on the include path and the checker bound by its file.
`timescale 1ns/1ps
`include "sms_defines.vh"
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin n_fail++; \
	$display("MISMATCH %s exp %h got %h", n, e, g); end end
`define PULSE(s) begin s <= 1; @(posedge clk_sys); s <= 0; \
	@(posedge clk_sys); end
module smi_status_and_rs485_dir_options_bench;
	localparam [11:0] A_OPT = {`SMS_IDX_OPT, 2'b00};
	localparam [11:0] A_S1 = {`SMS_IDX_STS1, 2'b00};
	localparam [11:0] A_S2 = {`SMS_IDX_STS2, 2'b00};
	localparam [1:0] OK = `SMS_RESP_OKAY;
	logic clk_sys = 0, reset_n = 0;
	logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
	logic [31:0] s_axi_wdata = 0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'h1;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready;
	logic s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic standby_por = 0, main_por = 0, bus_reset = 0, soft_reset = 0;
	logic battery_swapped = 0, battery_below_low = 0, battery_below_high = 0;
	logic parallel_active = 0, printer_acknowledge_input = 0;
	logic second_uart_irq = 0, first_uart_irq = 0, floppy_irq = 0;
	logic watchdog_event = 0, mouse_irq = 0, keyboard_irq = 0;
	logic infrared_receive_input = 0, mouse_click_event = 0;
	logic third_tx_active = 0, fourth_tx_active = 0;
	logic third_rts_in = 1, third_dtr_in = 0;
	logic fourth_rts_in = 1, fourth_dtr_in = 0;
	logic third_request_to_send_output, third_terminal_ready_output;
	logic fourth_request_to_send_output, fourth_terminal_ready_output;
	int n_fail = 0, checked = 0, i;
	logic [7:0] v;
	sms_status i_dut (.*);
	initial forever #2.5 clk_sys = ~clk_sys;
	// Verdict; also the landing place of any wait that runs out
	task automatic summarize;
		$display("checks %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic hang(input int n);
		if (n >= 64) begin
			n_fail++;
			summarize();
		end
	endtask
	// Address and data offered together, each dropped once taken
	task automatic wr(input [11:0] a, input [7:0] d, input [1:0] er);
		int n;
		s_axi_awaddr <= a;
		s_axi_awvalid <= 1;
		s_axi_wdata <= {24'h0, d};
		s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		for (n = 0; n < 64; n++) begin
			@(posedge clk_sys);
			if (s_axi_awready) s_axi_awvalid <= 0;
			if (s_axi_wready) s_axi_wvalid <= 0;
			if (s_axi_bvalid === 1'b1) break;
		end
		hang(n);
		s_axi_bready <= 0;
		`CHK("bresp", er, s_axi_bresp)
		@(posedge clk_sys);
	endtask
	task automatic rd(input [11:0] a, input [7:0] e, input [1:0] er);
		int n;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		for (n = 0; n < 64; n++) begin
			@(posedge clk_sys);
			if (s_axi_arready) s_axi_arvalid <= 0;
			if (s_axi_rvalid === 1'b1) break;
		end
		hang(n);
		s_axi_rready <= 0;
		`CHK("rresp", er, s_axi_rresp)
		`CHK("rdata", {24'h0, e}, s_axi_rdata)
		@(posedge clk_sys);
	endtask
	// Expected {request-to-send, terminal-ready} pins of one port
	function automatic [1:0] dir(input [2:0] o, input tx);
		logic p;
		p = o[2] ? tx : !tx;
		dir = {o[0] && o[1] ? p : 1'b1, o[0] && !o[1] ? p : 1'b0};
	endfunction
	initial begin
		repeat (12) @(posedge clk_sys);
		reset_n <= 1;
		@(posedge clk_sys);
		rd(A_OPT, 8'h44, OK);
		rd(A_S1, 8'h02, OK);
		rd(A_S2, 8'h00, OK);
		rd(12'h100, 8'h00, `SMS_RESP_SLVERR);
		wr(12'h100, 8'hff, `SMS_RESP_SLVERR);
		// Every option code, each with transmit idle and busy
		for (i = 0; i < 16; i++) begin
			v = i[7:0];
			wr(A_OPT, {1'b1, v[2:0], 1'b1, v[2:0]}, OK);
			third_tx_active <= v[3];
			fourth_tx_active <= !v[3];
			rd(A_OPT, {1'b0, v[2:0], 1'b0, v[2:0]}, OK);
			`CHK("dir3", dir(v[2:0], v[3]), {third_request_to_send_output, third_terminal_ready_output})
			`CHK("dir4", dir(v[2:0], !v[3]), {fourth_request_to_send_output, fourth_terminal_ready_output})
		end
		parallel_active <= 1;
		second_uart_irq <= 1;
		floppy_irq <= 1;
		watchdog_event <= 1;
		wr(A_S1, 8'hff, OK);
		rd(A_S1, 8'h94, OK);
		printer_acknowledge_input <= 1;
		second_uart_irq <= 0;
		first_uart_irq <= 1;
		rd(A_S1, 8'h9a, OK);
		parallel_active <= 0;
		printer_acknowledge_input <= 0;
		rd(A_S1, 8'h9a, OK);
		first_uart_irq <= 0;
		floppy_irq <= 0;
		watchdog_event <= 0;
		battery_below_low <= 1;
		`PULSE(standby_por)
		rd(A_S1, 8'h03, OK);
		wr(A_S1, 8'h00, OK);
		rd(A_S1, 8'h03, OK);
		wr(A_S1, 8'h01, OK);
		rd(A_S1, 8'h02, OK);
		battery_below_low <= 0;
		battery_below_high <= 1;
		`PULSE(main_por)
		rd(A_S1, 8'h03, OK);
		wr(A_S1, 8'h01, OK);
		battery_below_high <= 0;
		parallel_active <= 1;
		`PULSE(bus_reset)
		rd(A_S1, 8'h02, OK);
		parallel_active <= 0;
		@(posedge clk_sys);
		parallel_active <= 1;
		repeat (2) @(posedge clk_sys);
		rd(A_S1, 8'h00, OK);
		parallel_active <= 0;
		`PULSE(soft_reset)
		rd(A_S1, 8'h02, OK);
		mouse_irq <= 1;
		keyboard_irq <= 1;
		infrared_receive_input <= 1;
		`PULSE(mouse_click_event)
		rd(A_S2, 8'h17, OK);
		rd(A_S2, 8'h13, OK);
		wr(A_S2, 8'h00, OK);
		rd(A_S2, 8'h13, OK);
		wr(A_S2, 8'h10, OK);
		rd(A_S2, 8'h03, OK);
		mouse_irq <= 0;
		keyboard_irq <= 0;
		infrared_receive_input <= 0;
		battery_swapped <= 1;
		repeat (3) @(posedge clk_sys);
		`PULSE(standby_por)
		rd(A_S2, 8'h00, OK);
		rd(A_S1, 8'h03, OK);
		rd(A_OPT, 8'h44, OK);
		summarize();
	end
endmodule // smi_status_and_rs485_dir_options_bench

// [verif/sms_status_properties.sv]
// Checker of bus timing and read-back fields of the status block.
// Assumes binding into sms_status; it sees that module's ports only.
`timescale 1ns/1ps
`include "sms_defines.vh"
module sms_status_props (
	input logic clk_sys,
	input logic reset_n,
	input logic [11:0] s_axi_araddr,
	input logic s_axi_awvalid,
	input logic s_axi_awready,
	input logic s_axi_wvalid,
	input logic s_axi_wready,
	input logic s_axi_bvalid,
	input logic s_axi_bready,
	input logic [1:0] s_axi_bresp,
	input logic s_axi_arvalid,
	input logic s_axi_arready,
	input logic s_axi_rvalid,
	input logic s_axi_rready,
	input logic [31:0] s_axi_rdata,
	input logic [1:0] s_axi_rresp,
	input logic parallel_active
);
	localparam [11:0] A_OPT = {`SMS_IDX_OPT, 2'b00};
	localparam [11:0] A_S1 = {`SMS_IDX_STS1, 2'b00};
	localparam [11:0] A_S2 = {`SMS_IDX_STS2, 2'b00};
	logic [11:0] ra_q;
	// Address of the read in flight, so data can be judged per register
	always_ff @(posedge clk_sys or negedge reset_n)
		if (!reset_n) ra_q <= 12'h000;
		else if (s_axi_arvalid && s_axi_arready) ra_q <= s_axi_araddr;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!reset_n);
	// A write has two steps: both halves taken, then the answer
	sequence s_wr_take;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence s_wr_answer;
		##1 !s_axi_bvalid ##1 s_axi_bvalid;
	endsequence
	AST_WR_LAT: assert property (s_wr_take |-> s_wr_answer)
		else $error("write answer late or early");
	AST_BV_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp)) else $error("bvalid dropped");
	AST_RV_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata)) else $error("rvalid dropped");
	AST_RD_LAT: assert property (s_axi_arvalid && s_axi_arready |=>
		s_axi_rvalid) else $error("read answer late");
	AST_AR_PULSE: assert property (s_axi_arvalid && s_axi_arready |=>
		!s_axi_arready) else $error("arready held after take");
	AST_S1_RSV: assert property (s_axi_rvalid && ra_q == A_S1 |->
		s_axi_rdata[31:8] == 24'h0 && s_axi_rdata[6:5] == 2'b00)
		else $error("status one reserved bits set");
	AST_S2_RSV: assert property (s_axi_rvalid && ra_q == A_S2 |->
		!s_axi_rdata[3] && s_axi_rdata[7:5] == 3'h0 &&
		s_axi_rdata[31:8] == 24'h0)
		else $error("status two reserved bits set");
	AST_PAR: assert property (s_axi_rvalid && ra_q == A_S1 &&
		!$past(parallel_active) && !$past(parallel_active, 2) |->
		s_axi_rdata[1]) else $error("parallel flag low while inactive");
	AST_SLV: assert property (s_axi_rvalid && ra_q != A_OPT &&
		ra_q != A_S1 && ra_q != A_S2 |-> s_axi_rresp == `SMS_RESP_SLVERR
		&& s_axi_rdata == 32'h0) else $error("unmapped read answered");
endmodule // sms_status_props
bind sms_status sms_status_props i_props (.*);
